// ### rtl/cprc_ratio_ctrl.sv
// module: charge pump ratio controller with axi4-lite registers
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
module cprc_ratio_ctrl #(
  parameter int ADDR_W = 10,
  parameter int DEB_LONG = cprc_pkg::DEB_LONG_CYC,
  parameter int DEB_SHORT = cprc_pkg::DEB_SHORT_CYC,
  parameter int SOFT_START = cprc_pkg::SOFT_START_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analogue side
  input wire logic [cprc_pkg::NUM_SRC-1:0] low_headroom,
  input wire logic pattern_cycle_end,
  output logic [cprc_pkg::NUM_SRC-1:0] led_source_x,
  output cprc_pkg::cprc_pump_type pump_out
);
  import cprc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_idx;
    logic w_have;
    logic [31:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic force_en;
    logic auto_en;
    logic delay_sel;
    logic manual_sel;
    logic manual_ratio;
    logic clk_sel;
    logic [NUM_SRC-1:0] src_en;
    cprc_state_type state;
    logic [CNT_W-1:0] deb_cnt;
    logic [CNT_W-1:0] ss_cnt;
    logic [NUM_SRC-1:0] src_q;
    logic [NUM_SRC-1:0] low_q;
  } cprc_regs_type;

  cprc_regs_type r_q;
  cprc_regs_type r_d;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [NUM_SRC-1:0] src_on;
  logic any_on;
  logic any_low;
  logic pump_wanted;
  logic ratio_now;
  logic [CNT_W-1:0] deb_limit;
  logic do_write;
  logic [7:0] ar_idx;

  // sources gated off at each pattern cycle end
  assign src_on = r_q.src_en & {NUM_SRC{~pattern_cycle_end}}; // [RULE10]
  assign any_on = |src_on;
  // only enabled sources count toward low headroom
  assign any_low = |(low_headroom & src_on); // [RULE4] [RULE6]
  assign pump_wanted = r_q.force_en | r_q.auto_en;
  assign ratio_now = (r_q.state == ST_DOUBLE); // [RULE1]
  // debounce length from the delay select bit
  assign deb_limit = r_q.delay_sel ? CNT_W'(DEB_SHORT - 1) : CNT_W'(DEB_LONG - 1); // [RULE5]
  assign ar_idx = 8'(s_axi_araddr >> 2);

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  assign s_axi_awready = ~r_q.aw_have & ~r_q.bvalid;
  assign s_axi_wready = ~r_q.w_have & ~r_q.bvalid;
  assign s_axi_arready = ~r_q.rvalid;
  assign s_axi_bvalid = r_q.bvalid;
  assign s_axi_bresp = r_q.bresp;
  assign s_axi_rvalid = r_q.rvalid;
  assign s_axi_rdata = r_q.rdata;
  assign s_axi_rresp = r_q.rresp;
  assign do_write = r_q.aw_have & r_q.w_have & ~r_q.bvalid;

  // ----------------------------------------
  // analogue outputs
  // ----------------------------------------
  assign led_source_x = r_q.src_q;
  assign pump_out.run = (r_q.state != ST_OFF);
  assign pump_out.double_ratio = ratio_now;
  assign pump_out.soft_start = (r_q.ss_cnt != '0); // [RULE11]
  assign pump_out.clk_half = r_q.clk_sel;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.src_q = src_on;
    r_d.low_q = low_headroom & src_on;
    // write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      r_d.aw_have = 1'b1;
      r_d.aw_idx = 8'(s_axi_awaddr >> 2);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_d.w_have = 1'b1;
      r_d.w_data = s_axi_wdata;
      r_d.w_lane0 = s_axi_wstrb[0];
    end
    // register write once both halves are held
    if (do_write) begin
      r_d.aw_have = 1'b0;
      r_d.w_have = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = RESP_OKAY;
      unique case (r_q.aw_idx)
        REG_CTRL_IDX: begin
          if (r_q.w_lane0) begin
            r_d.force_en = r_q.w_data[CTRL_FORCE_BIT];
          end
        end
        REG_PUMP_IDX: begin
          if (r_q.w_lane0) begin
            r_d.auto_en = r_q.w_data[PUMP_AUTO_BIT];
            r_d.delay_sel = r_q.w_data[PUMP_DELAY_BIT];
            r_d.manual_sel = r_q.w_data[PUMP_MANUAL_BIT]; // [RULE14]
            r_d.manual_ratio = r_q.w_data[PUMP_RATIO_BIT]; // [RULE15]
            r_d.clk_sel = r_q.w_data[PUMP_CLK_BIT];
          end
        end
        REG_SRC_IDX: begin
          if (r_q.w_lane0) begin
            r_d.src_en = r_q.w_data[NUM_SRC-1:0];
          end
        end
        REG_STAT_IDX: r_d.bresp = RESP_OKAY;
        default: r_d.bresp = RESP_SLVERR;
      endcase
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end
    // read answer one cycle after the address is taken
    if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_d.rvalid = 1'b1;
      r_d.rdata = 32'h0000_0000;
      r_d.rresp = RESP_OKAY;
      unique case (ar_idx)
        REG_CTRL_IDX: r_d.rdata[CTRL_FORCE_BIT] = r_q.force_en;
        REG_PUMP_IDX: begin
          r_d.rdata[PUMP_AUTO_BIT] = r_q.auto_en;
          r_d.rdata[PUMP_DELAY_BIT] = r_q.delay_sel;
          r_d.rdata[PUMP_MANUAL_BIT] = r_q.manual_sel;
          r_d.rdata[PUMP_RATIO_BIT] = ratio_now; // [RULE15]
          r_d.rdata[PUMP_CLK_BIT] = r_q.clk_sel;
        end
        REG_SRC_IDX: r_d.rdata[NUM_SRC-1:0] = r_q.src_en;
        REG_STAT_IDX: begin
          r_d.rdata[NUM_SRC-1:0] = r_q.low_q;
          r_d.rdata[NUM_SRC+2:NUM_SRC] = r_q.state;
          r_d.rdata[NUM_SRC+3] = (r_q.ss_cnt != '0);
        end
        default: r_d.rresp = RESP_SLVERR;
      endcase
    end
    // soft start timer runs down
    if (r_q.ss_cnt != '0) begin
      r_d.ss_cnt = r_q.ss_cnt - CNT_W'(1);
    end
    // pump ratio state machine
    unique case (r_q.state)
      ST_OFF: begin
        r_d.deb_cnt = '0;
        // start needs an enable bit, a source and low headroom
        if (pump_wanted && any_on && any_low) begin // [RULE16] [RULE17] [RULE12]
          r_d.ss_cnt = CNT_W'(SOFT_START); // [RULE11]
          if (r_q.manual_sel && r_q.manual_ratio) begin // [RULE3]
            r_d.state = ST_DOUBLE;
          end else begin
            r_d.state = ST_BYPASS; // [RULE2]
          end
        end
      end
      ST_BYPASS: begin
        if (!pump_wanted || (!r_q.force_en && !any_on)) begin // [RULE16] [RULE17]
          r_d.state = ST_OFF;
        end else if (r_q.manual_sel) begin
          r_d.deb_cnt = '0;
          if (r_q.manual_ratio) begin // [RULE3]
            r_d.state = ST_DOUBLE;
            r_d.ss_cnt = CNT_W'(SOFT_START); // [RULE11]
          end
        end else if (!any_low) begin
          r_d.deb_cnt = '0; // [RULE13]
        end else if (r_q.deb_cnt >= deb_limit) begin
          r_d.deb_cnt = '0;
          r_d.state = ST_DOUBLE; // [RULE5]
          r_d.ss_cnt = CNT_W'(SOFT_START); // [RULE11]
        end else begin
          r_d.deb_cnt = r_q.deb_cnt + CNT_W'(1);
        end
      end
      ST_DOUBLE: begin
        r_d.deb_cnt = '0;
        if (!pump_wanted || (!r_q.force_en && !any_on)) begin // [RULE16]
          r_d.state = ST_OFF;
        end else if (!any_on && !r_q.manual_sel) begin
          // all sources off re-arms selection at bypass
          r_d.state = ST_BYPASS; // [RULE8] [RULE9]
          r_d.ss_cnt = CNT_W'(SOFT_START); // [RULE11]
        end else if (r_q.manual_sel && !r_q.manual_ratio) begin
          r_d.state = ST_BYPASS; // [RULE3]
          r_d.ss_cnt = CNT_W'(SOFT_START); // [RULE11]
        end
        // otherwise automatic mode holds doubling [RULE7]
      end
      default: r_d.state = ST_OFF;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q <= '0;
      r_q.force_en <= CTRL_RESET[CTRL_FORCE_BIT];
      r_q.auto_en <= PUMP_RESET[PUMP_AUTO_BIT];
      r_q.delay_sel <= PUMP_RESET[PUMP_DELAY_BIT];
      r_q.manual_sel <= PUMP_RESET[PUMP_MANUAL_BIT];
      r_q.manual_ratio <= PUMP_RESET[PUMP_RATIO_BIT];
      r_q.clk_sel <= PUMP_RESET[PUMP_CLK_BIT];
      r_q.src_en <= SRC_RESET[NUM_SRC-1:0];
      r_q.state <= ST_OFF;
    end else begin
      r_q <= r_d;
    end
  end
endmodule

// ### rtl/cprc_pkg.sv
// package: constants and types of the charge pump ratio controller
// How it works
// RULE1: two ratios only, bypass and doubling
// RULE2: automatic selection starts bypass, may double
// RULE3: manual selection applies written ratio only
// RULE4: low headroom on any enabled source
// RULE5: double after debounce, 32 ms or 200 us
// RULE6: software enables sources before pump start
// RULE7: automatic selection never steps down
// RULE8: selection re-arms only when all sources off
// RULE9: re-enabled sources re-evaluate from bypass
// RULE10: pattern cycle end switches sources off
// RULE11: soft start at power-on and ratio change
// RULE12: unused pump keeps both enables zero
// RULE13: headroom recovery restarts debounce timer
// RULE14: manual select bit: 0 auto, 1 manual
// RULE15: ratio bit written manually, reads ratio used
// RULE16: auto enable stops pump when sources off
// RULE17: force enable keeps pump running afterwards
package cprc_pkg;
  // ----------------------------------------
  // register map (indices, byte address is index times four)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL_IDX = 8'h00;
  localparam logic [7:0] REG_PUMP_IDX = 8'h23;
  localparam logic [7:0] REG_SRC_IDX = 8'h24;
  localparam logic [7:0] REG_STAT_IDX = 8'h25;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_FORCE_BIT = 2;
  localparam int PUMP_AUTO_BIT = 6;
  localparam int PUMP_DELAY_BIT = 5;
  localparam int PUMP_MANUAL_BIT = 4;
  localparam int PUMP_RATIO_BIT = 2;
  localparam int PUMP_CLK_BIT = 0;
  localparam int NUM_SRC = 4;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PUMP_RESET = 32'h0000_0000;
  localparam logic [31:0] SRC_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int DEB_LONG_MS = 32;
  localparam int DEB_SHORT_US = 200;
  localparam int SOFT_START_US = 100;
  localparam int SOFT_START_MA = 400;
  localparam int DEB_LONG_CYC = DEB_LONG_MS * 1000 * CLK_MHZ;
  localparam int DEB_SHORT_CYC = DEB_SHORT_US * CLK_MHZ;
  localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
  localparam int CNT_W = 22;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_BYPASS = 3'b010,
    ST_DOUBLE = 3'b100
  } cprc_state_type;
  typedef struct packed {
    logic run;
    logic double_ratio;
    logic soft_start;
    logic clk_half;
  } cprc_pump_type;
endpackage

// ### verif/cprc_ratio_ctrl_assertions.sv
// checker: port-level properties of the charge pump ratio controller
module cprc_ratio_ctrl_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analogue side
  input wire logic [cprc_pkg::NUM_SRC-1:0] low_headroom,
  input wire logic pattern_cycle_end,
  input wire logic [cprc_pkg::NUM_SRC-1:0] led_source_x,
  input wire cprc_pkg::cprc_pump_type pump_out
);
  import cprc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // stalled responses
  // ----------------------------------------
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  bresp_hold_a: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped while stalled");
  rdata_hold_a: assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped while stalled");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during read response");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during write response");
  // ----------------------------------------
  // pump behaviour
  // ----------------------------------------
  ratio_off_a: assert property (!pump_out.run |-> !pump_out.double_ratio)
    else $error("doubling flagged with pump off");
  pattern_off_a: assert property (pattern_cycle_end |=> led_source_x == '0)
    else $error("sources still on after pattern cycle end");
  soft_on_a: assert property ($rose(pump_out.run) |-> pump_out.soft_start)
    else $error("pump started without soft start");
  soft_up_a: assert property ($rose(pump_out.double_ratio) |-> pump_out.soft_start)
    else $error("ratio raised without soft start");
  start_cause_a: assert property ($rose(pump_out.run) |-> $past(|low_headroom))
    else $error("pump started without low headroom");
endmodule

bind cprc_ratio_ctrl cprc_ratio_ctrl_assertions u_chk (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .low_headroom, .pattern_cycle_end, .led_source_x, .pump_out);

// ### verif/cprc_partner.sv
// partner: analogue pump and current source headroom model
module cprc_partner (
  // controller outputs
  input wire logic [cprc_pkg::NUM_SRC-1:0] led_source_x,
  input wire cprc_pkg::cprc_pump_type pump_out,
  // battery sag from the bench
  input wire logic battery_low,
  // dropout comparators
  output logic [cprc_pkg::NUM_SRC-1:0] low_headroom
);
  import cprc_pkg::*;
  // only enabled sources drop out; a doubled rail restores headroom
  assign low_headroom = led_source_x
    & {NUM_SRC{battery_low & ~(pump_out.run & pump_out.double_ratio)}};
endmodule

// ### verif/cprc_ratio_ctrl_tb.sv
// testbench: register access and ratio selection of the pump controller
module cprc_ratio_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cprc_pkg::*;
  localparam int DL = 40;
  localparam int DS = 10;
  localparam logic [9:0] A_CTRL = {REG_CTRL_IDX, 2'b00};
  localparam logic [9:0] A_PUMP = {REG_PUMP_IDX, 2'b00};
  localparam logic [9:0] A_SRC = {REG_SRC_IDX, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, pattern_cycle_end = 0, battery_low = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] low_headroom, led_source_x;
  cprc_pump_type pump_out;
  logic [33:0] exp_q[$];
  int num_errors = 0, samples_checked = 0, cyc = 0;
  logic [31:0] seed = 32'hcbdf87dd;

  always #4 aclk = ~aclk;

  cprc_ratio_ctrl #(.DEB_LONG(DL), .DEB_SHORT(DS), .SOFT_START(5)) u_dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_headroom,
    .pattern_cycle_end, .led_source_x, .pump_out);
  cprc_partner u_far (.led_source_x, .pump_out, .battery_low, .low_headroom);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // write with both halves offered together, response stalled one cycle
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad = 1'b0;
    logic wd = 1'b0;
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !wd) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ad && wd));
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // read with the data phase stalled two cycles
  task automatic rd(input logic [9:0] a, input logic [1:0] r, input logic [31:0] d);
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat (2) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // response monitor: oldest note against each accepted response
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready) check({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid === 1'b1 && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end

  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    int c;
    int lim;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_CTRL, RESP_OKAY, CTRL_RESET);
    rd(A_PUMP, RESP_OKAY, PUMP_RESET);
    rd(A_SRC, RESP_OKAY, SRC_RESET);
    rd(10'h040, RESP_SLVERR, 32'h0);
    wr(10'h040, 32'hff, RESP_SLVERR);
    wr(10'h094, 32'hff, RESP_OKAY);
    rd(10'h094, RESP_OKAY, 32'h10);
    // automatic selection, long then short debounce
    for (int s = 0; s < 2; s++) begin
      lim = s ? DS : DL;
      seed = xs(seed);
      wr(A_SRC, {28'h0, seed[3:0] | 4'h1}, RESP_OKAY);
      wr(A_PUMP, {25'h0, 1'b1, s[0], 5'h00}, RESP_OKAY);
      battery_low <= 1'b1;
      c = 0;
      while (pump_out.run !== 1'b1 && c < 100) begin
        @(posedge aclk);
        c++;
      end
      check({32'h0, pump_out[3:2]}, 34'h2);
      repeat (lim / 2) @(posedge aclk);
      battery_low <= 1'b0;
      repeat (2) @(posedge aclk);
      battery_low <= 1'b1;
      c = 0;
      while (pump_out.double_ratio !== 1'b1 && c < 200) begin
        @(posedge aclk);
        c++;
      end
      check({33'h0, (c >= lim - 2 && c <= lim + 4)}, 34'h1);
      battery_low <= 1'b0;
      repeat (lim) @(posedge aclk);
      check({33'h0, pump_out.double_ratio}, 34'h1);
      rd(A_PUMP, RESP_OKAY, {25'h0, 1'b1, s[0], 5'h04});
      pattern_cycle_end <= 1'b1;
      @(posedge aclk);
      pattern_cycle_end <= 1'b0;
      repeat (4) @(posedge aclk);
      check({32'h0, pump_out[3:2]}, 34'h0);
    end
    // manual selection holds the written ratio under low headroom
    battery_low <= 1'b1;
    wr(A_PUMP, 32'h50, RESP_OKAY);
    repeat (DL + 10) @(posedge aclk);
    check({32'h0, pump_out[3:2]}, 34'h2);
    wr(A_PUMP, 32'h55, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check({32'h0, pump_out[3:2]}, 34'h3);
    check({33'h0, pump_out.clk_half}, 34'h1);
    rd(A_PUMP, RESP_OKAY, 32'h55);
    // forced enable keeps the pump with all sources off
    wr(A_CTRL, 32'h4, RESP_OKAY);
    wr(A_SRC, 32'h0, RESP_OKAY);
    repeat (4) @(posedge aclk);
    check({33'h0, pump_out.run}, 34'h1);
    wr(A_CTRL, 32'h0, RESP_OKAY);
    repeat (4) @(posedge aclk);
    check({33'h0, pump_out.run}, 34'h0);
    test_done();
  end
endmodule
